// ---- dv/osa_ctrl_properties.sv ----
// concurrent checks on the osa_ctrl pins and output state decisions
`timescale 1ns/1ps
module osa_ctrl_properties
   import osa_pkg::*;
(
   // clock and reset
   input wire logic          clk,
   input wire logic          rst,
   // observed ports
   input wire osa_alarm_type alarms,
   input wire logic          constant_voltage_regulation,
   input wire osa_cfg_type   cfg,
   input wire logic          cfg_pwron_write,
   input wire logic          power_up,
   input wire logic          remote_active,
   input wire logic          dc_off_req,
   input wire osa_pins_type  pins,
   input wire logic          dc_output_on,
   input wire logic          pwron_restore
);
   logic       p1;
   logic       p2;
   logic       p3;
   logic [2:0] s2;
   assign s2 = (cfg.pin2_sel == 3'h0) ? OSA_PIN2_DEFAULT : cfg.pin2_sel;
   assign p2 = |(s2 & {alarms.overpower_alarm, alarms.overcurrent_alarm, alarms.overvoltage_alarm});
   assign p1 = (cfg.pin1_sel == OSA_PIN1_OT) ? alarms.overtemp_alarm :
               (cfg.pin1_sel == OSA_PIN1_PF) ? alarms.power_fail_alarm :
               (alarms.overtemp_alarm | alarms.power_fail_alarm);
   assign p3 = cfg.pin3_dc_status ? dc_output_on : constant_voltage_regulation;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_exit_off;
      $fell(remote_active) && !cfg.remote_auto && !power_up;
   endsequence
   chk_pin1_route: assert property (!$past(rst) |-> pins.alarm_pin1 == $past(p1))
      else $error("first alarm pin mismatch");
   chk_pin2_route: assert property (!$past(rst) |-> pins.alarm_pin2 == $past(p2))
      else $error("second alarm pin mismatch");
   // dc status may lag its source by a cycle, so only judge it while dc is steady
   chk_pin3_route: assert property (!$past(rst) && $stable(dc_output_on) |-> pins.status_pin3 == $past(p3))
      else $error("status pin mismatch");
   chk_pf_forces_off: assert property (alarms.power_fail_alarm && !power_up |=> !dc_output_on)
      else $error("output on during power fail");
   chk_remote_exit_off: assert property (s_exit_off |=> !dc_output_on)
      else $error("output kept on after leaving remote");
   chk_off_req_off: assert property (dc_off_req && !power_up |=> !dc_output_on)
      else $error("off request ignored");
   chk_pwron_off: assert property (power_up && !pwron_restore |=> !dc_output_on)
      else $error("output on after power up with setting off");
   chk_pwron_write: assert property (cfg_pwron_write |=> pwron_restore == $past(cfg.pwron_restore))
      else $error("power on setting not loaded");
endmodule : osa_ctrl_properties

bind osa_ctrl osa_ctrl_properties i_props (
   .clk                         (clk),
   .rst                         (rst),
   .alarms                      (alarms),
   .constant_voltage_regulation (constant_voltage_regulation),
   .cfg                         (cfg),
   .cfg_pwron_write             (cfg_pwron_write),
   .power_up                    (power_up),
   .remote_active               (remote_active),
   .dc_off_req                  (dc_off_req),
   .pins                        (pins),
   .dc_output_on                (dc_output_on),
   .pwron_restore               (pwron_restore)
);

// ---- dv/osa_ext_ctrl.sv ----
// external controller model driving the standby pin of the analog interface
`timescale 1ns/1ps
module osa_ext_ctrl (
   // clock
   input  wire logic clk,
   // requested standby and wiring polarity
   input  wire logic standby_req,
   input  wire logic inverted,
   // analog interface pin
   output logic      remote_standby_input
);
   // pin moves just after the rising edge of the same clock that samples it inside
   always_ff @(posedge clk) begin
      remote_standby_input <= standby_req ^ inverted;
   end
endmodule : osa_ext_ctrl

// ---- dv/test_osa_ctrl.sv ----
// self-checking bench for osa_ctrl
`timescale 1ns/1ps
module test_osa_ctrl;
   import osa_pkg::*;
   logic          clk = 1'h0;
   logic          rst = 1'h1;
   osa_alarm_type alarms;
   osa_cfg_type   cfg;
   osa_pins_type  pins;
   logic          cv, wr, pu, ar, ra, on_r, off_r, saved, sb, inv, pin, dc, pr;
   int            n_errors = 0;
   int            checks_done = 0;
   // rows: alarms {ot,pf,ov,oc,op}, pin1 select, pin2 select, cv, expected pins
   logic [13:0]   rows [16] = '{
      {5'h10, 2'h0, 3'h1, 1'h1, 3'h5}, {5'h08, 2'h0, 3'h1, 1'h0, 3'h0}, {5'h10, 2'h1, 3'h1, 1'h0, 3'h0},
      {5'h08, 2'h1, 3'h1, 1'h0, 3'h4}, {5'h10, 2'h2, 3'h1, 1'h0, 3'h4}, {5'h08, 2'h2, 3'h1, 1'h0, 3'h4},
      {5'h08, 2'h3, 3'h1, 1'h0, 3'h4}, {5'h04, 2'h2, 3'h0, 1'h0, 3'h2}, {5'h02, 2'h2, 3'h1, 1'h0, 3'h0},
      {5'h02, 2'h2, 3'h2, 1'h0, 3'h2}, {5'h01, 2'h2, 3'h4, 1'h0, 3'h2}, {5'h01, 2'h2, 3'h3, 1'h0, 3'h0},
      {5'h04, 2'h2, 3'h5, 1'h0, 3'h2}, {5'h02, 2'h2, 3'h6, 1'h0, 3'h2}, {5'h01, 2'h2, 3'h7, 1'h0, 3'h2},
      {5'h04, 2'h2, 3'h6, 1'h0, 3'h0}};
   always #10 clk = ~clk;
   osa_ext_ctrl i_ext (.clk(clk), .standby_req(sb), .inverted(inv), .remote_standby_input(pin));
   osa_ctrl i_dut (.clk(clk), .rst(rst), .remote_standby_input(pin), .alarms(alarms),
      .constant_voltage_regulation(cv), .cfg(cfg), .cfg_pwron_write(wr), .power_up(pu),
      .analog_remote(ar), .remote_active(ra), .dc_on_req(on_r), .dc_off_req(off_r),
      .last_state_saved(saved), .pins(pins), .dc_output_on(dc), .pwron_restore(pr));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_pins(input osa_pins_type got, input osa_pins_type exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_pins
   task automatic cmp_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_bit
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic pulse(ref logic s);
      s = 1'h1;
      tick(1);
      s = 1'h0;
      tick(1);
   endtask : pulse
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      n_errors++;
      conclude();
   end
   initial begin
      {alarms, cv, wr, pu, ar, ra, on_r, off_r, saved, sb, inv} = '0;
      cfg = '0;
      cfg.pin1_sel = OSA_PIN1_DEFAULT;
      cfg.pin2_sel = OSA_PIN2_DEFAULT;
      tick(2);
      rst = 1'h0;
      tick(1);
      cmp_bit(pr, 1'h0);
      cmp_bit(dc, 1'h0);
      foreach (rows[i]) begin
         alarms = rows[i][13:9];
         cfg.pin1_sel = osa_pin1_sel_type'(rows[i][8:7]);
         cfg.pin2_sel = rows[i][6:4];
         cv = rows[i][3];
         tick(1);
         cmp_pins(pins, rows[i][2:0]);
      end
      alarms = '0;
      cfg.pf_auto = 1'h1;
      pulse(on_r);
      alarms.power_fail_alarm = 1'h1;
      tick(1);
      cmp_bit(dc, 1'h0);
      alarms.power_fail_alarm = 1'h0;
      tick(3);
      cmp_bit(dc, 1'h1);
      cfg.pf_auto = 1'h0;
      alarms.power_fail_alarm = 1'h1;
      tick(1);
      alarms.power_fail_alarm = 1'h0;
      tick(3);
      cmp_bit(dc, 1'h0);
      // off-only standby: refuses on requests and never restores
      pulse(on_r);
      sb = 1'h1;
      tick(8);
      cmp_bit(dc, 1'h0);
      pulse(on_r);
      sb = 1'h0;
      tick(8);
      cmp_bit(dc, 1'h0);
      cfg.standby_on_off = 1'h1;
      pulse(on_r);
      sb = 1'h1;
      tick(8);
      cmp_bit(dc, 1'h0);
      sb = 1'h0;
      tick(8);
      cmp_bit(dc, 1'h1);
      sb = 1'h1;
      tick(8);
      pulse(off_r);
      sb = 1'h0;
      tick(8);
      cmp_bit(dc, 1'h0);
      // inverted wiring: low pin means standby
      inv = 1'h1;
      cfg.standby_inverted = 1'h1;
      tick(8);
      pulse(on_r);
      sb = 1'h1;
      tick(8);
      cmp_bit(dc, 1'h0);
      sb = 1'h0;
      tick(8);
      cmp_bit(dc, 1'h1);
      ar = 1'h1;
      sb = 1'h1;
      tick(8);
      cmp_bit(dc, 1'h1);
      sb = 1'h0;
      ar = 1'h0;
      tick(8);
      // switch on under remote so that leaving it has something to force off
      ra = 1'h1;
      pulse(on_r);
      ra = 1'h0;
      tick(1);
      cmp_bit(dc, 1'h0);
      cfg.remote_auto = 1'h1;
      ra = 1'h1;
      pulse(on_r);
      ra = 1'h0;
      tick(1);
      cmp_bit(dc, 1'h1);
      cfg.pin3_dc_status = 1'h1;
      tick(2);
      cmp_bit(pins.status_pin3, 1'h1);
      pulse(saved);
      cfg.pwron_restore = 1'h1;
      pulse(wr);
      cmp_bit(pr, 1'h1);
      pulse(off_r);
      pulse(pu);
      cmp_bit(dc, 1'h1);
      cfg.pwron_restore = 1'h0;
      pulse(wr);
      pulse(pu);
      cmp_bit(dc, 1'h0);
      cfg.pwron_restore = 1'h1;
      pulse(wr);
      rst = 1'h1;
      tick(2);
      rst = 1'h0;
      tick(1);
      cmp_bit(pr, 1'h0);
      conclude();
   end
endmodule : test_osa_ctrl

// ---- rtl/osa_ctrl.sv ----
// output state decision and analog interface alarm/status pin routing
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module osa_ctrl
   import osa_pkg::*;
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // analog interface input pin (asynchronous)
   input  wire logic          remote_standby_input,
   // alarms and status from the power stage
   input  wire osa_alarm_type alarms,
   input  wire logic          constant_voltage_regulation,
   // configuration
   input  wire osa_cfg_type   cfg,
   input  wire logic          cfg_pwron_write,
   // control location requests and events
   input  wire logic          power_up,
   input  wire logic          analog_remote,
   input  wire logic          remote_active,
   input  wire logic          dc_on_req,
   input  wire logic          dc_off_req,
   input  wire logic          last_state_saved,
   // outputs
   output osa_pins_type       pins,
   output logic               dc_output_on,
   output logic               pwron_restore
);

   ////////////////////////////////////////////////////////////////////////////
   // standby pin conditioning
   logic standby_level;
   logic standby_active;
   logic standby_prev;
   logic standby_assert;
   logic standby_release;
   logic [2:0] settle_cnt;
   logic standby_valid;

   osa_sync u_sync (
      .clk   (clk),
      .rst   (rst),
      .pin   (remote_standby_input),
      .level (standby_level)
   );

   // the synchroniser resets low, which reads as standby under inverted polarity;
   // ignore the pin until real samples have reached its output
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settle_cnt <= 3'h0;
      end else if (!standby_valid) begin
         settle_cnt <= settle_cnt + 3'h1;
      end
   end

   assign standby_valid = (settle_cnt == OSA_SYNC_SETTLE);

   // inverted polarity flips only the active level, not the action taken on it
   assign standby_active  = standby_valid & (standby_level ^ cfg.standby_inverted);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         standby_prev <= 1'b0;
      end else begin
         standby_prev <= standby_active;
      end
   end

   assign standby_assert  = standby_active & ~standby_prev;
   assign standby_release = ~standby_active & standby_prev;

   ////////////////////////////////////////////////////////////////////////////
   // event edges
   logic pf_prev;
   logic remote_prev;
   logic pf_rise;
   logic pf_fall;
   logic remote_exit;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pf_prev     <= 1'b0;
         remote_prev <= 1'b0;
      end else begin
         pf_prev     <= alarms.power_fail_alarm;
         remote_prev <= remote_active;
      end
   end

   assign pf_rise     = alarms.power_fail_alarm & ~pf_prev;
   assign pf_fall     = ~alarms.power_fail_alarm & pf_prev;
   assign remote_exit = remote_prev & ~remote_active;

   ////////////////////////////////////////////////////////////////////////////
   // power-on setting register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwron_restore <= OSA_PWRON_RESET;
      end else if (cfg_pwron_write) begin
         pwron_restore <= cfg.pwron_restore;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory of states that decide re-enable
   logic last_off_state;   // output state at last switch-off of the device
   logic on_before_pf;     // output was on when power fail arrived
   logic on_before_sb;     // output switched on elsewhere before standby took it off

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_off_state <= OSA_DC_RESET;
      end else if (last_state_saved) begin
         last_off_state <= dc_output_on;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         on_before_pf <= 1'b0;
      end else if (pf_rise) begin
         on_before_pf <= dc_output_on;
      end else if (pf_fall || dc_off_req) begin
         on_before_pf <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         on_before_sb <= 1'b0;
      end else if (standby_assert && !analog_remote) begin
         on_before_sb <= dc_output_on;
      end else if (standby_release || dc_off_req) begin
         on_before_sb <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dc output decision; power-up decides alone, then off causes take priority over on causes
   logic next_dc;

   always_comb begin
      next_dc = dc_output_on;
      if (power_up) begin
         next_dc = pwron_restore & last_off_state;
      end else if (alarms.power_fail_alarm) begin
         next_dc = 1'b0;
      end else if (remote_exit && !cfg.remote_auto) begin
         next_dc = 1'b0;
      end else if (!analog_remote && standby_active) begin
         next_dc = 1'b0;
      end else if (dc_off_req) begin
         next_dc = 1'b0;
      end else if (pf_fall && cfg.pf_auto && on_before_pf) begin
         next_dc = 1'b1;
      end else if (!analog_remote && standby_release && cfg.standby_on_off && on_before_sb) begin
         next_dc = 1'b1;
      end else if (dc_on_req) begin
         next_dc = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dc_output_on <= OSA_DC_RESET;
      end else begin
         dc_output_on <= next_dc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin routing, recomputed every cycle
   logic       next_pin1;
   logic       next_pin2;
   logic       next_pin3;
   logic [2:0] pin2_src;

   assign pin2_src = {alarms.overpower_alarm, alarms.overcurrent_alarm, alarms.overvoltage_alarm};

   always_comb begin
      unique case (cfg.pin1_sel)
         OSA_PIN1_OT:   next_pin1 = alarms.overtemp_alarm;
         OSA_PIN1_PF:   next_pin1 = alarms.power_fail_alarm;
         OSA_PIN1_BOTH: next_pin1 = alarms.overtemp_alarm | alarms.power_fail_alarm;
         default:       next_pin1 = alarms.overtemp_alarm | alarms.power_fail_alarm;
      endcase
   end

   // code zero is not a legal combination; it falls back to overvoltage only
   assign next_pin2 = (cfg.pin2_sel == 3'h0) ? alarms.overvoltage_alarm
                                             : |(pin2_src & cfg.pin2_sel);
   assign next_pin3 = cfg.pin3_dc_status ? dc_output_on : constant_voltage_regulation;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins <= '0;
      end else begin
         pins.alarm_pin1  <= next_pin1;
         pins.alarm_pin2  <= next_pin2;
         pins.status_pin3 <= next_pin3;
      end
   end

endmodule : osa_ctrl

// ---- rtl/osa_pkg.sv ----
// package: settings, encodings and carriers for the output state and alarm pin block
package osa_pkg;

   // first alarm pin selection
   typedef enum logic [1:0] {
      OSA_PIN1_OT   = 2'h0,
      OSA_PIN1_PF   = 2'h1,
      OSA_PIN1_BOTH = 2'h2
   } osa_pin1_sel_type;

   // second alarm pin selection: bit0 overvoltage, bit1 overcurrent, bit2 overpower
   localparam logic [2:0] OSA_PIN2_OV_BIT     = 3'h1;
   localparam logic [2:0] OSA_PIN2_DEFAULT    = 3'h1;
   localparam int         OSA_PIN2_SEL_WIDTH  = 3;

   localparam osa_pin1_sel_type OSA_PIN1_DEFAULT = OSA_PIN1_BOTH;
   localparam logic             OSA_PIN3_DEFAULT = 1'b0; // 0 regulation, 1 dc status
   localparam logic             OSA_PWRON_RESET  = 1'b0; // 0 off, 1 restore
   localparam logic             OSA_DC_RESET     = 1'b0;
   // cycles after reset until the synchronised standby level is trustworthy
   localparam logic [2:0]       OSA_SYNC_SETTLE  = 3'h4;

   typedef struct packed {
      logic overtemp_alarm;
      logic power_fail_alarm;
      logic overvoltage_alarm;
      logic overcurrent_alarm;
      logic overpower_alarm;
   } osa_alarm_type;

   typedef struct packed {
      logic             standby_on_off;   // 0 off only, 1 on/off
      logic             standby_inverted; // 0 normal, 1 inverted
      osa_pin1_sel_type pin1_sel;
      logic [2:0]       pin2_sel;
      logic             pin3_dc_status;
      logic             pwron_restore;    // requested power-on setting
      logic             pf_auto;
      logic             remote_auto;
   } osa_cfg_type;

   typedef struct packed {
      logic alarm_pin1;
      logic alarm_pin2;
      logic status_pin3;
   } osa_pins_type;

endpackage : osa_pkg

// ---- rtl/osa_sync.sv ----
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module osa_sync
   import osa_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pin and filtered level
   input  wire logic pin,
   output logic      level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts only once the second and third stages agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule : osa_sync
